// >>> design/lfg_fire_guard_buffer.sv
// Purpose: Laser fire rate guard and range rate buffer
// Assumes: All inputs synchronous to clk_i
// Notes:   Spacing counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`include "lfg_params.svh"

module lfg_fire_guard_buffer #(
    parameter int SLOW_CYCLES = `LFG_SLOW_US * `LFG_CLK_MHZ,
    parameter int FAST_CYCLES = `LFG_FAST_US * `LFG_CLK_MHZ,
    parameter int FIFO_DEPTH  = `LFG_FIFO_DEPTH
) (
    // Clock, reset, enable
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    ce_i,
    input  wire logic                    power_up_reset_i,
    // Fire request sources
    input  wire logic                    mirror_encoder_pulse_i,
    input  wire logic                    elevation_hit_latched_i,
    input  wire logic                    azimuth_hit_latched_i,
    input  wire logic [1:0]              rate_select_i,
    // Receiver and scan data
    input  wire logic                    rx_data_ready_i,
    input  wire logic [`LFG_RANGE_W-1:0] rx_range_i,
    input  wire logic [`LFG_SHOT_W-1:0]  shot_sequence_number_i,
    input  wire logic                    scan_complete_flag_i,
    input  wire logic                    elevation_sweep_complete_flag_i,
    // Telemetry requests
    input  wire logic                    tlm_laser_selected_i,
    input  wire logic                    tlm_word_rate_i,
    // Laser side
    output logic                         fire_laser_o,
    output logic                         fast_limit_led_o,
    output logic                         power_on_clear_pulse_o,
    // Buffered telemetry side
    output logic                         laser_data_here_o,
    output logic [`LFG_RANGE_W-1:0]      buf_range_o,
    output logic [`LFG_SHOT_W-1:0]       buf_shot_o,
    output logic                         buf_scan_complete_o,
    output logic                         buf_elev_complete_o
);
    localparam int IW = $clog2(`LFG_INIT_CYCLES + 1);

    typedef struct packed {
        lfg_pkg::lfg_guard_t guard;
        logic                fire;
        logic                fast_led;
        logic                here;
        logic                req_d;
        logic                rdy_d;
        logic                so_n_d;
        logic                pur_d;
        logic [IW-1:0]       init_cnt;
        logic                init;
    } lfg_top_t;

    lfg_top_t            st;
    lfg_top_t            next_st;
    lfg_pkg::lfg_mode_t  mode;
    logic                req;
    logic                req_rise;
    logic                sel_busy;
    logic                start;
    logic [1:0]          busy;
    logic                so_n;
    logic                so_fall;
    logic                rdy_rise;
    logic                wr_ok;
    logic [2:0]          slice_full;
    logic [2:0]          slice_output_ready;
    logic [`LFG_FLAG_W-1:0] flags_in;
    logic [`LFG_FLAG_W-1:0] flags_out;

    // Setting decode and request forming
    always_comb begin
        mode     = lfg_pkg::lfg_decode(rate_select_i);
        req      = elevation_hit_latched_i && azimuth_hit_latched_i
                   && mirror_encoder_pulse_i;
        req_rise = req && !st.req_d;
        sel_busy = (mode == lfg_pkg::LFG_MODE_FAST) ? busy[1] : busy[0];
    end

    // Buffer strobes: capture on ready rise, shift on strobe fall
    always_comb begin
        so_n     = !(tlm_laser_selected_i && tlm_word_rate_i);
        so_fall  = st.so_n_d && !so_n;
        rdy_rise = rx_data_ready_i && !st.rdy_d;
        wr_ok    = rdy_rise && !st.init;
        flags_in = '0;
        flags_in[`LFG_FLAG_SCAN] = scan_complete_flag_i;
        flags_in[`LFG_FLAG_ELEV] = elevation_sweep_complete_flag_i;
    end

    // Guard, init pulse and indicator next state
    always_comb begin
        next_st        = st;
        start          = 1'b0;
        next_st.req_d  = req;
        next_st.rdy_d  = rx_data_ready_i;
        next_st.so_n_d = so_n;
        next_st.pur_d  = power_up_reset_i;
        next_st.here   = &slice_output_ready;
        next_st.fast_led = (mode == lfg_pkg::LFG_MODE_FAST);
        // Short clearing pulse after reset or a power-up rise
        if (power_up_reset_i && !st.pur_d) begin
            next_st.init_cnt = IW'(`LFG_INIT_CYCLES);
        end else if (st.init_cnt != '0) begin
            next_st.init_cnt = st.init_cnt - 1'b1;
        end
        next_st.init = (next_st.init_cnt != '0);
        unique case (st.guard)
            lfg_pkg::LFG_GRD_IDLE: begin
                // Early edges are dropped, not held back
                if (req_rise && !sel_busy && !st.init
                    && mode != lfg_pkg::LFG_MODE_OFF) begin
                    start         = 1'b1;
                    next_st.fire  = 1'b1;
                    next_st.guard = lfg_pkg::LFG_GRD_FIRE;
                end
            end
            lfg_pkg::LFG_GRD_FIRE: begin
                // Pulse follows the request until it drops
                if (!req) begin
                    next_st.fire  = 1'b0;
                    next_st.guard = lfg_pkg::LFG_GRD_IDLE;
                end
            end
        endcase
        // Disable or clearing pulse forces the laser line low
        if (mode == lfg_pkg::LFG_MODE_OFF || st.init) begin
            next_st.fire  = 1'b0;
            next_st.guard = lfg_pkg::LFG_GRD_IDLE;
        end
        if (st.init) begin
            next_st.here = 1'b0;
        end
    end

    // State register; reset starts a clearing pulse too
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st          <= '0;
            st.init_cnt <= IW'(`LFG_INIT_CYCLES);
            st.init     <= 1'b1;
            st.so_n_d   <= 1'b1;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // Two one-shots, started by every accepted shot
    generate
        for (genvar i = 0; i < 2; i++) begin : g_timer
            lfg_spacing_timer #(
                .COUNT (i == 0 ? SLOW_CYCLES : FAST_CYCLES)
            ) u_timer (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .ce_i    (ce_i),
                .clear_i (st.init),
                .start_i (start),
                .busy_o  (busy[i])
            );
        end
    endgenerate

    // Range slice
    lfg_slice_mem #(
        .W     (`LFG_RANGE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_range (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .clear_i     (st.init),
        .wr_i        (wr_ok),
        .wr_data_i   (rx_range_i),
        .full_o      (slice_full[0]),
        .rd_i        (so_fall),
        .out_ready_o (slice_output_ready[0]),
        .rd_data_o   (buf_range_o)
    );

    // Shot number slice
    lfg_slice_mem #(
        .W     (`LFG_SHOT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_shot (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .clear_i     (st.init),
        .wr_i        (wr_ok),
        .wr_data_i   (shot_sequence_number_i),
        .full_o      (slice_full[1]),
        .rd_i        (so_fall),
        .out_ready_o (slice_output_ready[1]),
        .rd_data_o   (buf_shot_o)
    );

    // Flag slice
    lfg_slice_mem #(
        .W     (`LFG_FLAG_W),
        .DEPTH (FIFO_DEPTH)
    ) u_flags (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .clear_i     (st.init),
        .wr_i        (wr_ok),
        .wr_data_i   (flags_in),
        .full_o      (slice_full[2]),
        .rd_i        (so_fall),
        .out_ready_o (slice_output_ready[2]),
        .rd_data_o   (flags_out)
    );

    // Outputs from registers
    assign fire_laser_o           = st.fire;
    assign fast_limit_led_o       = st.fast_led;
    assign power_on_clear_pulse_o = st.init;
    assign laser_data_here_o      = st.here;
    assign buf_scan_complete_o    = flags_out[`LFG_FLAG_SCAN];
    assign buf_elev_complete_o    = flags_out[`LFG_FLAG_ELEV];

    // Gap since the last fire rise, for spacing checks
    logic [15:0] gap;
    logic        seen;
    int          sel_cnt;
    always_comb begin
        sel_cnt = (mode == lfg_pkg::LFG_MODE_FAST) ? FAST_CYCLES : SLOW_CYCLES;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gap  <= '0;
            seen <= 1'b0;
        end else if (ce_i) begin
            if (next_st.fire && !st.fire) begin
                gap  <= '0;
                seen <= 1'b1;
            end else if (gap != 16'hFFFF) begin
                gap <= gap + 16'h0001;
            end
        end
    end

    sequence accepted_edge_s;
        ce_i && st.guard == lfg_pkg::LFG_GRD_IDLE && req_rise && !sel_busy
        && !st.init && mode != lfg_pkg::LFG_MODE_OFF;
    endsequence

    sequence pur_rise_s;
        ce_i && power_up_reset_i && !st.pur_d;
    endsequence

    disable_blocks_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && mode == lfg_pkg::LFG_MODE_OFF |=> !fire_laser_o)
        else $error("laser fired while disabled");

    rise_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && seen && next_st.fire && !st.fire |-> int'(gap) + 1 >= sel_cnt)
        else $error("fire edges closer than selected interval");

    accept_fire_a: assert property (@(posedge clk_i) disable iff (rst_i)
        accepted_edge_s |=> fire_laser_o)
        else $error("allowed request did not fire");

    early_dropped_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req_rise && sel_busy && !fire_laser_o |=> !fire_laser_o)
        else $error("request fired while timer running");

    request_and_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(fire_laser_o) |-> $past(req))
        else $error("fire without combined request");

    fast_led_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && mode == lfg_pkg::LFG_MODE_FAST ##1 ce_i |-> fast_limit_led_o)
        else $error("fast limit indicator dark");

    init_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pur_rise_s |=> power_on_clear_pulse_o && !fire_laser_o)
        else $error("power-up did not clear");

    write_shows_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr_ok && slice_output_ready == 3'h0 && !st.init
        ##1 ce_i [*4] |-> laser_data_here_o)
        else $error("captured entry not offered");

    here_and_a: assert property (@(posedge clk_i) disable iff (rst_i)
        laser_data_here_o |-> $past(&slice_output_ready))
        else $error("data-here without all slices ready");

    // Each slice drops a write on its own when full, so they must stay in step
    slices_agree_a: assert property (@(posedge clk_i) disable iff (rst_i)
        slice_full == {3{slice_full[0]}} && slice_output_ready == {3{slice_output_ready[0]}})
        else $error("buffer slices out of step");

endmodule

// >>> design/lfg_params.svh
// Purpose: Shared constants of the laser fire guard and rate buffer
// Assumes: 50 MHz clock
// Notes:   Definitions only
`ifndef LFG_PARAMS_SVH
`define LFG_PARAMS_SVH

// Clock rate and spacing times
`define LFG_CLK_MHZ      50
`define LFG_SLOW_US      200
`define LFG_FAST_US      100

// Length of the power-on clear pulse in cycles
`define LFG_INIT_CYCLES  16

// Rate select codes; any other code disables firing
`define LFG_SEL_SLOW     2'h0
`define LFG_SEL_FAST     2'h1
`define LFG_SEL_OFF      2'h2

// Buffer slice widths and default depth
`define LFG_RANGE_W      10
`define LFG_SHOT_W       10
`define LFG_FLAG_W       2
`define LFG_FLAG_SCAN    1
`define LFG_FLAG_ELEV    0
`define LFG_FIFO_DEPTH   64

`endif

// >>> design/lfg_pkg.sv
// Purpose: Types and the mode decode of the laser fire guard
// Assumes: lfg_params.svh gives the select codes
// Notes:   Nothing here is imported; use lfg_pkg::name
`include "lfg_params.svh"

package lfg_pkg;

    // Fire rate setting
    typedef enum logic [1:0] {
        LFG_MODE_SLOW,
        LFG_MODE_FAST,
        LFG_MODE_OFF
    } lfg_mode_t;

    // Fire guard states
    typedef enum logic {
        LFG_GRD_IDLE,
        LFG_GRD_FIRE
    } lfg_guard_t;

    // Decode the rate select inputs; unknown codes fall to disable
    function automatic lfg_mode_t lfg_decode(input logic [1:0] sel);
        lfg_mode_t m;
        m = LFG_MODE_OFF;
        if (sel == `LFG_SEL_SLOW) begin
            m = LFG_MODE_SLOW;
        end else if (sel == `LFG_SEL_FAST) begin
            m = LFG_MODE_FAST;
        end
        return m;
    endfunction

endpackage

// >>> design/lfg_spacing_timer.sv
// Purpose: One-shot interval timer for minimum fire spacing
// Assumes: COUNT of at least one cycle
// Notes:   busy_o stays high for COUNT cycles after a start
`timescale 1ns/1ps

module lfg_spacing_timer #(
    parameter int COUNT = 5000
) (
    // Clock, reset, enable
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // Control
    input  wire logic clear_i,
    input  wire logic start_i,
    // Status
    output logic      busy_o
);
    localparam int CW = $clog2(COUNT + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          busy;
    } lfg_tmr_t;

    lfg_tmr_t st;
    lfg_tmr_t next_st;

    // Load on start, count down to zero
    always_comb begin
        next_st = st;
        if (clear_i) begin
            next_st = '0;
        end else if (start_i) begin
            next_st.cnt  = CW'(COUNT);
            next_st.busy = 1'b1;
        end else if (st.cnt != '0) begin
            next_st.cnt  = st.cnt - 1'b1;
            next_st.busy = (st.cnt != CW'(1));
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign busy_o = st.busy;

    start_runs_timer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && start_i && !clear_i |=> busy_o)
        else $error("spacing timer not running after start");

endmodule

// >>> design/lfg_slice_mem.sv
// Purpose: One slice of the rate buffer, first in first out
// Assumes: DEPTH is a power of two
// Notes:   Head word waits in a register; out_ready_o marks it valid
`timescale 1ns/1ps

module lfg_slice_mem #(
    parameter int W     = 10,
    parameter int DEPTH = 64
) (
    // Clock, reset, enable
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic         clear_i,
    // Fill side
    input  wire logic         wr_i,
    input  wire logic [W-1:0] wr_data_i,
    output logic              full_o,
    // Drain side
    input  wire logic         rd_i,
    output logic              out_ready_o,
    output logic [W-1:0]      rd_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
        logic          rdy;
        logic [W-1:0]  data;
    } lfg_mem_t;

    lfg_mem_t     st;
    lfg_mem_t     next_st;
    logic [W-1:0] mem [DEPTH];
    logic         push;
    logic         pop;
    logic         load;

    // Writes to a full slice are dropped; head refills after a read
    always_comb begin
        next_st = st;
        push    = wr_i && !full_o && !clear_i;
        pop     = rd_i && st.rdy;
        load    = (!st.rdy || pop) && (st.cnt != '0);
        if (push) begin
            next_st.wp = st.wp + 1'b1;
        end
        if (load) begin
            next_st.data = mem[st.rp];
            next_st.rp   = st.rp + 1'b1;
            next_st.rdy  = 1'b1;
        end else if (pop) begin
            next_st.rdy  = 1'b0;
        end
        next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        if (clear_i) begin
            next_st = '0;
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // Storage array
    always_ff @(posedge clk_i) begin
        if (ce_i && push) begin
            mem[st.wp] <= wr_data_i;
        end
    end

    assign full_o      = (st.cnt == (AW+1)'(DEPTH));
    assign out_ready_o = st.rdy;
    assign rd_data_o   = st.data;

    full_keeps_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr_i && full_o && !pop && !clear_i |=> st.cnt == $past(st.cnt))
        else $error("full slice took a write");

    read_empties_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && pop && st.cnt == '0 && !push && !clear_i |=> !out_ready_o)
        else $error("last word not removed by read");

endmodule

// >>> test/lfg_far_side_model.sv
// Purpose: Receiver, telemetry and laser around the fire guard and rate buffer
// Assumes: Driven one ns after the rising clock edge
// Notes:   Laser edge spacing is logged for the bench
`timescale 1ns/1ps

module lfg_far_side_model (
    // Clock
    input  wire logic  clk_i,
    // Device outputs watched
    input  wire logic  fire_laser_i,
    input  wire logic  laser_data_here_i,
    // Receiver side
    output logic       rx_data_ready_o,
    output logic [9:0] rx_range_o,
    // Telemetry side
    output logic       tlm_laser_selected_o,
    output logic       tlm_word_rate_o
);
    // Range word stays valid 30 us after the ready rise, 1500 cycles at 50 MHz
    localparam int RX_VALID = 1500;

    int   clear_req  = 0;
    int   clear_seen = 0;
    int   cyc       = 0;
    int   last_rise = 0;
    int   rises     = 0;
    int   min_gap   = 0;
    int   max_gap   = 0;
    logic fire_q    = 1'b0;

    // Idle lines at time zero; range word idles garbled
    initial begin
        rx_data_ready_o = 1'b0;
        rx_range_o = 10'h155;
        tlm_laser_selected_o = 1'b0;
        tlm_word_rate_o = 1'b0;
    end

    // Laser acts on leading edges only; spacing between them is logged
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        fire_q <= fire_laser_i;
        if (clear_seen != clear_req) begin
            clear_seen <= clear_req;
            rises <= 0;
            min_gap <= 0;
            max_gap <= 0;
        end else if (fire_laser_i && !fire_q) begin
            rises <= rises + 1;
            last_rise <= cyc;
            if (rises == 1 || (rises > 1 && cyc - last_rise < min_gap)) begin
                min_gap <= cyc - last_rise;
            end
            if (rises > 0 && cyc - last_rise > max_gap) begin
                max_gap <= cyc - last_rise;
            end
        end
    end

    // Forget logged laser edges at the next clock; only the logger writes the counts
    task automatic clear_stats();
        clear_req = clear_req + 1;
    endtask

    // Receiver: ready low when idle, word valid for 30 us from the rise, garbled after
    task automatic rx_send(input logic [9:0] word, input int hold);
        @(posedge clk_i);
        #1;
        rx_range_o = word;
        rx_data_ready_o = 1'b1;
        repeat (hold) @(posedge clk_i);
        #1;
        rx_data_ready_o = 1'b0;
        if (hold < RX_VALID) begin
            repeat (RX_VALID - hold) @(posedge clk_i);
            #1;
        end
        rx_range_o = ~word;
    endtask

    // Telemetry word slot; with_sel low gives word rate alone
    task automatic tlm_word(input logic with_sel);
        @(posedge clk_i);
        #1;
        tlm_laser_selected_o = with_sel;
        @(posedge clk_i);
        #1;
        tlm_word_rate_o = 1'b1;
        @(posedge clk_i);
        #1;
        tlm_word_rate_o = 1'b0;
        tlm_laser_selected_o = 1'b0;
    endtask

    // Telemetry picks laser data first whenever it is waiting
    task automatic tlm_take();
        for (int i = 0; i < 10 && !laser_data_here_i; i++) @(posedge clk_i);
        tlm_word(laser_data_here_i);
    endtask
endmodule

// >>> test/laser_fire_guard_rate_buffer_bench.sv
// Purpose: Self-checking bench of the fire guard and rate buffer
// Assumes: Spacing shortened to 40/20 cycles, buffer depth 4 (five entries)
// Notes:   Request edges come every 5 cycles in the rate table
`timescale 1ns/1ps

`define CHK(what, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module laser_fire_guard_rate_buffer_bench;
    localparam int SLOW = 40;
    localparam int FAST = 20;

    typedef struct {
        logic [1:0] rs;
        logic       az;
        logic       led;
        int         cnt;
    } lfg_bench_row_t;

    // Rate setting, azimuth flag, lamp, spacing (0 = nothing fires)
    lfg_bench_row_t rows [5] = '{'{2'h0, 1'b1, 1'b0, SLOW}, '{2'h1, 1'b1, 1'b1, FAST},
                                 '{2'h2, 1'b1, 1'b0, 0}, '{2'h3, 1'b1, 1'b0, 0},
                                 '{2'h0, 1'b0, 1'b0, 0}};

    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       ce = 1'b1;
    logic       pur = 1'b0;
    logic       enc = 1'b0;
    logic       elev = 1'b1;
    logic       az = 1'b1;
    logic [1:0] rate_sel = 2'h0;
    logic [9:0] shot = 10'h000;
    logic       scan = 1'b0;
    logic       sweep = 1'b0;
    logic       rdy, sel, wrate, fire, led, clr, here, bscan, belev;
    logic [9:0] rng, brng, bshot;
    int         num_errors = 0;
    int         checked = 0;

    // 50 MHz clock
    always #10 clk_i = ~clk_i;

    lfg_fire_guard_buffer #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST), .FIFO_DEPTH(4)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .power_up_reset_i(pur),
        .mirror_encoder_pulse_i(enc), .elevation_hit_latched_i(elev), .azimuth_hit_latched_i(az),
        .rate_select_i(rate_sel), .rx_data_ready_i(rdy), .rx_range_i(rng),
        .shot_sequence_number_i(shot), .scan_complete_flag_i(scan),
        .elevation_sweep_complete_flag_i(sweep), .tlm_laser_selected_i(sel), .tlm_word_rate_i(wrate),
        .fire_laser_o(fire), .fast_limit_led_o(led), .power_on_clear_pulse_o(clr),
        .laser_data_here_o(here), .buf_range_o(brng), .buf_shot_o(bshot),
        .buf_scan_complete_o(bscan), .buf_elev_complete_o(belev));

    lfg_far_side_model far (
        .clk_i(clk_i), .fire_laser_i(fire), .laser_data_here_i(here), .rx_data_ready_o(rdy),
        .rx_range_o(rng), .tlm_laser_selected_o(sel), .tlm_word_rate_o(wrate));

    // Wait n edges, then step off the edge
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Encoder pulses: 2 high, 3 low, n times
    task automatic req_train(input int n);
        for (int i = 0; i < n; i++) begin
            enc = 1'b1;
            cycles(2);
            enc = 1'b0;
            cycles(3);
        end
    endtask

    // Accepted requests among n edges 5 apart, dropped while busy
    function automatic int exp_fires(input int cnt, input int n);
        int k;
        int t;
        k = 0;
        t = -1000;
        for (int i = 0; i < n; i++) begin
            if (i * 5 >= t + cnt + 1) begin
                k++;
                t = i * 5;
            end
        end
        return k;
    endfunction

    // Print counts and verdict, then stop
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Cut a hang short
    initial begin
        #400us;
        num_errors++;
        $display("[FAIL] watchdog expected done seen hang");
        conclude();
    end

    // Main sequence
    initial begin
        cycles(5);
        `CHK("clear_in_reset", 1'b1, clr);
        `CHK("fire_in_reset", 1'b0, fire);
        cycles(5);
        rst_i = 1'b0;
        cycles(8);
        `CHK("clear_running", 1'b1, clr);
        ce = 1'b0;
        cycles(20);
        `CHK("clear_frozen", 1'b1, clr);
        ce = 1'b1;
        cycles(10);
        `CHK("clear_done", 1'b0, clr);
        $display("reset test done");

        foreach (rows[r]) begin
            rate_sel = rows[r].rs;
            az = rows[r].az;
            cycles(SLOW + 5);
            `CHK("fast_limit_led", rows[r].led, led);
            far.clear_stats();
            req_train(20);
            cycles(3);
            `CHK("fire_rises", (rows[r].cnt == 0) ? 0 : exp_fires(rows[r].cnt, 20), far.rises);
            if (rows[r].cnt != 0) begin
                `CHK("min_gap", ((rows[r].cnt + 5) / 5) * 5, far.min_gap);
                `CHK("max_gap", ((rows[r].cnt + 5) / 5) * 5, far.max_gap);
            end
            $display("rate row %0d done", r);
        end

        // Six entries into room for five; the sixth is lost
        for (int i = 0; i < 6; i++) begin
            shot = 10'h100 + 10'(i);
            scan = i[1];
            sweep = i[0];
            far.rx_send(10'h2A0 + 10'(i), (i == 0) ? 1500 : 4);
            cycles(2);
        end
        cycles(3);
        `CHK("data_here_full", 1'b1, here);
        for (int i = 0; i < 5; i++) begin
            `CHK("buf_range", 10'h2A0 + 10'(i), brng);
            `CHK("buf_shot", 10'h100 + 10'(i), bshot);
            `CHK("buf_scan", i[1], bscan);
            `CHK("buf_elev", i[0], belev);
            far.tlm_take();
            cycles(3);
        end
        `CHK("data_here_empty", 1'b0, here);
        $display("fill and drain test done");

        // New entry after overflow; word rate alone must not read it
        far.rx_send(10'h2B7, 4);
        cycles(4);
        far.tlm_word(1'b0);
        cycles(3);
        `CHK("unselected_read", 10'h2B7, brng);
        `CHK("unselected_here", 1'b1, here);
        far.tlm_word(1'b1);
        cycles(3);
        `CHK("selected_read", 1'b0, here);
        far.tlm_word(1'b1);
        cycles(3);
        `CHK("empty_read", 1'b0, here);
        $display("read strobe test done");

        // Power-up reset mid-run clears the buffer and blocks firing
        rate_sel = 2'h1;
        az = 1'b1;
        far.rx_send(10'h0F0, 4);
        cycles(SLOW);
        pur = 1'b1;
        cycles(2);
        `CHK("clear_on_powerup", 1'b1, clr);
        `CHK("here_cleared", 1'b0, here);
        far.clear_stats();
        req_train(2);
        `CHK("fire_in_clear", 0, far.rises);
        pur = 1'b0;
        cycles(20);
        `CHK("clear_ends", 1'b0, clr);
        $display("power-up test done");
        conclude();
    end
endmodule
